// *** verilog/conv_status_flags.v ***
// status register, ready pin mirror and data read framing of the converter
// assumes a serial engine that decodes the communications byte and gives
// one-cycle strobes, all synchronous to SYS_CLK
`timescale 1ns/100ps
`default_nettype none
`include "status_consts.vh"

module conv_status_flags #(
    parameter DATA_W = 24,
    parameter SUM_W = 8
) (
    input wire SYS_CLK,
    input wire RST,
    input wire CS_N,
    input wire READ_BUSY,
    input wire RD_REQ,
    input wire [5:0] RD_ADDR,
    input wire WR_REQ,
    input wire [5:0] WR_ADDR,
    input wire WR_CSUM_BAD,
    input wire APPEND_STATUS,
    input wire CAL_MODE,
    input wire RESULT_STORE,
    input wire CAL_STORE,
    input wire [DATA_W-1:0] RESULT_RAW,
    input wire RESULT_OVER,
    input wire RESULT_UNDER,
    input wire [3:0] RESULT_CHAN,
    input wire INTEG_EN,
    input wire [SUM_W-1:0] REG_SUM,
    output reg [7:0] STATUS,
    output reg [DATA_W-1:0] DATA,
    output reg [31:0] READ_DATA,
    output reg [5:0] READ_BITS,
    output reg READ_VALID,
    output reg DOUT_RDY,
    output reg DOUT_OE,
    output reg FILTER_RESET
);

    // ****************************************
    // flag state
    // ****************************************
    reg ready_n_q, ready_n_d;
    reg range_q, range_d;
    reg csum_q, csum_d;
    reg integ_q, integ_d;
    reg [3:0] chan_q, chan_d;
    reg [DATA_W-1:0] data_d;
    reg [SUM_W-1:0] sum_ref_q;
    reg integ_en_q;
    wire store_evt;
    wire rd_status;
    wire rd_data;
    wire wr_mode;
    wire [7:0] status_now;
    wire [7:0] status_next;

    assign rd_status = RD_REQ && (RD_ADDR == `ADDR_STATUS);
    assign rd_data = RD_REQ && (RD_ADDR == `ADDR_DATA);
    assign wr_mode = WR_REQ && !WR_CSUM_BAD && (WR_ADDR == `ADDR_MODE);
    // calibration store replaces result store in calibration modes
    assign store_evt = CAL_MODE ? CAL_STORE : RESULT_STORE;
    assign status_now[`BIT_READY_N] = ready_n_q;
    assign status_now[`BIT_RANGE_ERR] = range_q;
    assign status_now[`BIT_CSUM_ERR] = csum_q;
    assign status_now[`BIT_INTEG_ERR] = integ_q;
    assign status_now[`CHAN_MSB:`CHAN_LSB] = chan_q;
    assign status_next[`BIT_READY_N] = ready_n_d;
    assign status_next[`BIT_RANGE_ERR] = range_d;
    assign status_next[`BIT_CSUM_ERR] = csum_d;
    assign status_next[`BIT_INTEG_ERR] = integ_d;
    assign status_next[`CHAN_MSB:`CHAN_LSB] = chan_d;

    // ****************************************
    // ready flag
    // ****************************************
    always @* begin
        ready_n_d = ready_n_q;
        if (rd_data || wr_mode) begin
            ready_n_d = 1'b1;
        end
        if (store_evt) begin
            ready_n_d = 1'b0;
        end
    end

    // ****************************************
    // range error, channel and stored result
    // ****************************************
    always @* begin
        range_d = range_q;
        chan_d = chan_q;
        data_d = DATA;
        if (RESULT_STORE && !CAL_MODE) begin
            range_d = RESULT_OVER | RESULT_UNDER;
            chan_d = RESULT_CHAN;
            if (RESULT_OVER) begin
                data_d = {DATA_W{1'b1}};
            end else if (RESULT_UNDER) begin
                data_d = {DATA_W{1'b0}};
            end else begin
                data_d = RESULT_RAW;
            end
        end
    end

    // ****************************************
    // checksum error flag
    // ****************************************
    always @* begin
        csum_d = csum_q;
        if (rd_status) begin
            csum_d = 1'b0;
        end
        if (WR_REQ && WR_CSUM_BAD) begin
            csum_d = 1'b1;
        end
    end

    // ****************************************
    // register integrity flag
    // ****************************************
    always @* begin
        integ_d = integ_q;
        if (!INTEG_EN) begin
            integ_d = 1'b0;
        end else if (integ_en_q && (REG_SUM != sum_ref_q)) begin
            integ_d = 1'b1;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    // writes to the status address reach no flag except the checksum error flag, which any write with a bad checksum sets
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ready_n_q <= 1'b1;
            range_q <= 1'b0;
            csum_q <= 1'b0;
            integ_q <= 1'b0;
            chan_q <= 4'h0;
            sum_ref_q <= {SUM_W{1'b0}};
            integ_en_q <= 1'b0;
            STATUS <= `STATUS_RESET;
            DATA <= {DATA_W{1'b0}};
            FILTER_RESET <= 1'b0;
        end else begin
            ready_n_q <= ready_n_d;
            range_q <= range_d;
            csum_q <= csum_d;
            integ_q <= integ_d;
            chan_q <= chan_d;
            integ_en_q <= INTEG_EN;
            if (INTEG_EN && !integ_en_q) begin
                sum_ref_q <= REG_SUM;
            end
            STATUS <= status_next;
            DATA <= data_d;
            FILTER_RESET <= wr_mode;
        end
    end

    // ****************************************
    // read framing, msb first
    // ****************************************
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            READ_DATA <= 32'h00000000;
            READ_BITS <= 6'h00;
            READ_VALID <= 1'b0;
        end else begin
            READ_VALID <= rd_status || rd_data;
            if (rd_status) begin
                READ_DATA <= {status_now, 24'h000000};
                READ_BITS <= `BITS_STATUS;
            end else if (rd_data) begin
                if (APPEND_STATUS) begin
                    READ_DATA <= {DATA, status_now};
                    READ_BITS <= `BITS_DATA_STAT;
                end else begin
                    READ_DATA <= {DATA, 8'h00};
                    READ_BITS <= `BITS_DATA;
                end
            end
        end
    end

    // ****************************************
    // ready mirror on shared output
    // ****************************************
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            DOUT_RDY <= 1'b1;
            DOUT_OE <= 1'b0;
        end else begin
            DOUT_RDY <= ready_n_d;
            DOUT_OE <= !CS_N && !READ_BUSY;
        end
    end

endmodule // conv_status_flags
`default_nettype wire

// *** verilog/status_consts.vh ***
// constants of the converter status register logic
// assumes inclusion by bare name from the status flag module
`ifndef STATUS_CONSTS_VH
`define STATUS_CONSTS_VH

// ****************************************
// register addresses
// ****************************************
`define ADDR_STATUS 6'h00
`define ADDR_MODE 6'h01
`define ADDR_DATA 6'h04

// ****************************************
// status bit layout and reset value
// ****************************************
`define STATUS_RESET 8'h80
`define BIT_READY_N 7
`define BIT_RANGE_ERR 6
`define BIT_CSUM_ERR 5
`define BIT_INTEG_ERR 4
`define CHAN_MSB 3
`define CHAN_LSB 0

// ****************************************
// clamped results and frame lengths
// ****************************************
`define RESULT_FULL 24'hffffff
`define RESULT_ZERO 24'h000000
`define BITS_STATUS 6'h08
`define BITS_DATA 6'h18
`define BITS_DATA_STAT 6'h20

`endif

// *** tb/status_props.sv ***
// assertions on the status flag block
// assumes a bind onto conv_status_flags
`timescale 1ns/100ps
`default_nettype none
module status_props (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CS_N,
    input wire logic READ_BUSY,
    input wire logic RD_REQ,
    input wire logic WR_REQ,
    input wire logic WR_CSUM_BAD,
    input wire logic APPEND_STATUS,
    input wire logic CAL_MODE,
    input wire logic CAL_STORE,
    input wire logic RESULT_STORE,
    input wire logic RESULT_OVER,
    input wire logic READ_VALID,
    input wire logic DOUT_RDY,
    input wire logic DOUT_OE,
    input wire logic [5:0] RD_ADDR,
    input wire logic [5:0] READ_BITS,
    input wire logic [7:0] STATUS,
    input wire logic [23:0] DATA,
    input wire logic [31:0] READ_DATA
);
    wire st = RESULT_STORE && !CAL_MODE;
    wire dr = RD_REQ && RD_ADDR == 6'h04;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    a_store_ready: assert property (st |=> !STATUS[7]) else $error("ready high");
    a_cal_ready: assert property (CAL_MODE && CAL_STORE |=> !STATUS[7]) else $error("cal");
    a_read_ready: assert property (dr && !st && !(CAL_MODE && CAL_STORE) |=> STATUS[7])
        else $error("ready low");
    a_over_clamp: assert property (st && RESULT_OVER |=> DATA == 24'hffffff && STATUS[6])
        else $error("clamp");
    a_range_hold: assert property (!st |=> $stable(STATUS[6])) else $error("range");
    a_csum_set: assert property (WR_REQ && WR_CSUM_BAD |=> STATUS[5]) else $error("csum");
    a_csum_clear: assert property (RD_REQ && RD_ADDR == 6'h00 && !WR_REQ |=> !STATUS[5])
        else $error("csum clr");
    a_pin_mirror: assert property (!CS_N && !READ_BUSY |=> DOUT_OE && DOUT_RDY == STATUS[7])
        else $error("pin");
    a_pin_release: assert property (CS_N || READ_BUSY |=> !DOUT_OE)
        else $error("pin driven");
    a_data_frame: assert property (dr && APPEND_STATUS |=> READ_VALID && READ_BITS == 6'h20
        && READ_DATA == {$past(DATA), $past(STATUS)}) else $error("frame");
endmodule // status_props
bind conv_status_flags status_props u_status_props (.*);
`default_nettype wire

// *** tb/host_model.sv ***
// host side of the register interface
// assumes the block's SYS_CLK
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic SYS_CLK,
    output var logic RD_REQ,
    output var logic WR_REQ,
    output var logic WR_CSUM_BAD,
    output var logic [5:0] RD_ADDR,
    output var logic [5:0] WR_ADDR
);
    initial {RD_REQ, WR_REQ, WR_CSUM_BAD, RD_ADDR, WR_ADDR} = 15'h0;
    task rd(input logic [5:0] a);
        @(posedge SYS_CLK) {RD_REQ, RD_ADDR} <= {1'h1, a};
        @(posedge SYS_CLK) {RD_REQ, RD_ADDR} <= {1'h0, ~a};
        #1;
    endtask
    task wr(input logic [5:0] a, input logic bad);
        @(posedge SYS_CLK) {WR_REQ, WR_ADDR, WR_CSUM_BAD} <= {1'h1, a, bad};
        @(posedge SYS_CLK) {WR_REQ, WR_ADDR, WR_CSUM_BAD} <= {1'h0, ~a, ~bad};
        #1;
    endtask
endmodule // host_model
`default_nettype wire

// *** tb/tb_conv_status_flags.sv ***
// self-checking bench of the status flag block
// assumes the host model drives the register strobes
`timescale 1ns/100ps
`default_nettype none
module tb_conv_status_flags;
    logic SYS_CLK = 1'h0, RST = 1'h1, CS_N = 1'h1, READ_BUSY = 1'h0, APPEND_STATUS = 1'h0;
    logic CAL_MODE = 1'h0, RESULT_STORE = 1'h0, CAL_STORE = 1'h0, RESULT_OVER = 1'h0;
    logic RESULT_UNDER = 1'h0, INTEG_EN = 1'h0, RD_REQ, WR_REQ, WR_CSUM_BAD;
    logic READ_VALID, DOUT_RDY, DOUT_OE, FILTER_RESET;
    logic [5:0] RD_ADDR, WR_ADDR, READ_BITS;
    logic [3:0] RESULT_CHAN = 4'h0;
    logic [7:0] REG_SUM = 8'h11, STATUS;
    logic [23:0] RESULT_RAW = 24'h0, DATA;
    logic [31:0] READ_DATA;
    int num_errors = 0, checked = 0, cyc = 0;
    conv_status_flags u_conv_status_flags (.*);
    host_model u_host_model (.*);
    always #10 SYS_CLK = ~SYS_CLK;
    task chk(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %s exp %h got %h", n, e, g);
        end
    endtask
    task st(input logic [23:0] r, input logic o, u, input logic [3:0] c);
        @(posedge SYS_CLK) {RESULT_STORE, RESULT_RAW, RESULT_OVER, RESULT_UNDER, RESULT_CHAN}
            <= {1'h1, r, o, u, c};
        @(posedge SYS_CLK) RESULT_STORE <= 1'h0;
        #1;
    endtask
    task close_out;
        if (num_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge SYS_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            close_out;
        end
    end
    initial begin
        repeat (12) @(posedge SYS_CLK);
        RST <= 1'h0;
        @(posedge SYS_CLK) #1;
        chk("status", 8'h80, STATUS);
        st(24'h123456, 1'h0, 1'h0, 4'hf);
        chk("status", 8'h0f, STATUS);
        u_host_model.rd(6'h04);
        chk("frame", 32'h12345600, READ_DATA);
        chk("valid", 1'h1, READ_VALID);
        chk("bits", 6'h18, READ_BITS);
        chk("status", 8'h8f, STATUS);
        st(24'h0, 1'h1, 1'h0, 4'h0);
        chk("data", 24'hffffff, DATA);
        chk("status", 8'h40, STATUS);
        st(24'hffffff, 1'h0, 1'h1, 4'h3);
        chk("data", 24'h0, DATA);
        st(24'h00abcd, 1'h0, 1'h0, 4'h5);
        chk("status", 8'h05, STATUS);
        @(posedge SYS_CLK) APPEND_STATUS <= 1'h1;
        u_host_model.rd(6'h04);
        chk("frame", 32'h00abcd05, READ_DATA);
        chk("bits", 6'h20, READ_BITS);
        u_host_model.wr(6'h00, 1'h0);
        chk("status", 8'h85, STATUS);
        u_host_model.wr(6'h01, 1'h1);
        chk("status", 8'ha5, STATUS);
        chk("filter", 1'h0, FILTER_RESET);
        u_host_model.rd(6'h00);
        chk("frame", 8'ha5, READ_DATA[31:24]);
        chk("status", 8'h85, STATUS);
        u_host_model.wr(6'h01, 1'h0);
        chk("filter", 1'h1, FILTER_RESET);
        @(posedge SYS_CLK) CAL_MODE <= 1'h1;
        st(24'h000001, 1'h0, 1'h0, 4'h9);
        chk("status", 8'h85, STATUS);
        @(posedge SYS_CLK) CAL_STORE <= 1'h1;
        @(posedge SYS_CLK) {CAL_STORE, CAL_MODE, INTEG_EN} <= 3'h1;
        #1 chk("status", 8'h05, STATUS);
        repeat (2) @(posedge SYS_CLK);
        REG_SUM <= 8'h12;
        repeat (2) @(posedge SYS_CLK);
        #1 chk("status", 8'h15, STATUS);
        @(posedge SYS_CLK) {REG_SUM, CS_N} <= {8'h11, 1'h0};
        repeat (2) @(posedge SYS_CLK);
        #1 chk("status", 8'h15, STATUS);
        chk("pin", 2'h1, {DOUT_RDY, DOUT_OE});
        @(posedge SYS_CLK) {INTEG_EN, READ_BUSY} <= 2'h1;
        @(posedge SYS_CLK) #1 chk("status", 8'h05, STATUS);
        chk("pin", 2'h0, {DOUT_RDY, DOUT_OE});
        u_host_model.wr(6'h01, 1'h0);
        chk("status", 8'h85, STATUS);
        close_out;
    end
endmodule // tb_conv_status_flags
`default_nettype wire
